// *** src/dtc_regs.vh ***
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// ==========================================================
// register indices (byte address = index * 4)
`define DTC_IDX_TIMER_CONTROL    8'h88
`define DTC_IDX_TIMER_MODE    8'h89
`define DTC_IDX_TL0     8'h8A
`define DTC_IDX_TL1     8'h8B
`define DTC_IDX_TH0     8'h8C
`define DTC_IDX_TH1     8'h8D
`define DTC_IDX_AUX     8'h8E
`define DTC_IDX_CLKO    8'h8F

// ==========================================================
// reset values
`define DTC_RST_BYTE    8'h00

// ==========================================================
// timer_control bits
`define DTC_TF1_BIT     7
`define DTC_TR1_BIT     6
`define DTC_TF0_BIT     5
`define DTC_TR0_BIT     4

// ==========================================================
// timer_mode fields (timer 1 upper nibble, timer 0 lower)
`define DTC_T1_GATE_BIT 7
`define DTC_T1_CT_BIT   6
`define DTC_T1_MODE_HI  5
`define DTC_T1_MODE_LO  4
`define DTC_T0_GATE_BIT 3
`define DTC_T0_CT_BIT   2
`define DTC_T0_MODE_HI  1
`define DTC_T0_MODE_LO  0

// ==========================================================
// aux_config and wake_clockout_control bits
`define DTC_T0_FAST_BIT 7
`define DTC_T1_FAST_BIT 6
`define DTC_T1_CLKO_BIT 1
`define DTC_T0_CLKO_BIT 0

// ==========================================================
// modes
`define DTC_MODE_13BIT  2'b00
`define DTC_MODE_16BIT  2'b01
`define DTC_MODE_RELOAD 2'b10
`define DTC_MODE_SPLIT  2'b11

// ==========================================================
// timing
`define DTC_DIV_SLOW    4'hC
`define DTC_DIV_LAST    4'hB

`endif

// *** src/dtc_top.v ***
// How it works
// - timer ticks every clock or every twelve
// - aux bit 7 sets timer 0 prescale
// - aux bit 6 sets timer 1 prescale
// - count pin falling edge via sampled pair
// - edge count visible two cycles after the pin falls
// - edge needs two samples, rate limited
// - source select: clock path or pin
// - mode field per timer nibble
// - mode 0: 13-bit, 5-bit prescaler
// - mode 1: 16-bit cascade
// - mode 2: low byte auto-reloads
// - timer 0 split into two bytes
// - timer 1 in mode 3 holds
// - gate bit needs gate pin high
// - timer 0 output toggles on overflow
// - timer 1 output toggles on overflow
// - rollover sets overflow flag; timer 1 rollover only while timer 0 is not in mode 3
// - reload leaves high byte unchanged
// - run bit clear keeps present count, except timer 1 while timer 0 is in mode 3
`include "dtc_regs.vh"

module dtc_top #(
	parameter AW = 12
) (
	input  wire          clk,
	input  wire          arst_n,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [AW-1:0] paddr,
	input  wire [31:0]   pwdata,
	input  wire [3:0]    pstrb,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	input  wire          count_input_0,
	input  wire          count_input_1,
	input  wire          ext_gate_pin_0,
	input  wire          ext_gate_pin_1,
	output reg           timer0_output_pin,
	output reg           timer1_output_pin,
	output reg           timer0_overflow_flag,
	output reg           timer1_overflow_flag
);

	// ==========================================================
	// step function: {overflow, high, low}
	function [16:0] dtc_step;
		input [1:0] m;
		input [7:0] lo;
		input [7:0] hi;
		reg   [16:0] r;
		begin
			r = {1'b0, hi, lo};
			case (m)
			`DTC_MODE_13BIT: begin
				r[4:0] = lo[4:0] + 5'h01;
				if (lo[4:0] == 5'h1F) begin
					r[15:8] = hi + 8'h01;
					r[16]   = (hi == 8'hFF);
				end
			end
			`DTC_MODE_16BIT: begin
				r = {1'b0, hi, lo} + 17'h00001;
			end
			`DTC_MODE_RELOAD: begin
				if (lo == 8'hFF) begin
					r = {1'b1, hi, hi};
				end else begin
					r[7:0] = lo + 8'h01;
				end
			end
			`DTC_MODE_SPLIT: begin
				r[7:0] = lo + 8'h01;
				r[16]  = (lo == 8'hFF);
			end
			default: begin
				r = {1'b0, hi, lo};
			end
			endcase
			dtc_step = r;
		end
	endfunction

	// ==========================================================
	// registers
	reg  [7:0] timer_control_reg;
	reg  [7:0] timer_mode_reg;
	reg  [7:0] tl0_reg;
	reg  [7:0] tl1_reg;
	reg  [7:0] th0_reg;
	reg  [7:0] th1_reg;
	reg  [7:0] aux_reg;
	reg  [7:0] clko_reg;
	reg  [3:0] div_reg;
	reg        cin0_reg;
	reg        cin0_old_reg;
	reg        cin1_reg;
	reg        cin1_old_reg;
	reg  [7:0] timer_control_next;
	reg  [7:0] tl0_next;
	reg  [7:0] tl1_next;
	reg  [7:0] th0_next;
	reg  [7:0] th1_next;
	reg  [7:0] rd_byte;
	reg        rd_hit;
	reg  [16:0] s0;
	reg  [16:0] s1;
	reg        ovf0;
	reg        ovf1;
	reg        ovf_th0;

	// ==========================================================
	// bus decode
	wire [7:0] widx     = paddr[9:2];
	wire       aligned  = (paddr[1:0] == 2'b00) &&
	                      (paddr[AW-1:10] == {(AW-10){1'b0}});
	wire       access   = psel & penable;
	wire       wr_go    = access & pready & pwrite & pstrb[0];
	wire       wr_timer_control  = wr_go && aligned && widx == `DTC_IDX_TIMER_CONTROL;
	wire       wr_timer_mode  = wr_go && aligned && widx == `DTC_IDX_TIMER_MODE;
	wire       wr_tl0   = wr_go && aligned && widx == `DTC_IDX_TL0;
	wire       wr_tl1   = wr_go && aligned && widx == `DTC_IDX_TL1;
	wire       wr_th0   = wr_go && aligned && widx == `DTC_IDX_TH0;
	wire       wr_th1   = wr_go && aligned && widx == `DTC_IDX_TH1;
	wire       wr_aux   = wr_go && aligned && widx == `DTC_IDX_AUX;
	wire       wr_clko  = wr_go && aligned && widx == `DTC_IDX_CLKO;

	// ==========================================================
	// count enables
	wire       tick12   = (div_reg == `DTC_DIV_LAST);
	wire       fast0    = aux_reg[`DTC_T0_FAST_BIT];
	wire       fast1    = aux_reg[`DTC_T1_FAST_BIT];
	wire       tick0    = fast0 | tick12;
	wire       tick1    = fast1 | tick12;
	wire       fall0    = cin0_old_reg & ~cin0_reg;
	wire       fall1    = cin1_old_reg & ~cin1_reg;
	wire [1:0] mode0    = timer_mode_reg[`DTC_T0_MODE_HI:`DTC_T0_MODE_LO];
	wire [1:0] mode1    = timer_mode_reg[`DTC_T1_MODE_HI:`DTC_T1_MODE_LO];
	wire       split0   = (mode0 == `DTC_MODE_SPLIT);
	wire       ev0      = timer_mode_reg[`DTC_T0_CT_BIT] ? fall0 : tick0;
	wire       ev1      = timer_mode_reg[`DTC_T1_CT_BIT] ? fall1 : tick1;
	wire       tr0      = timer_control_reg[`DTC_TR0_BIT];
	wire       tr1      = timer_control_reg[`DTC_TR1_BIT];
	wire       run0     = tr0 & (~timer_mode_reg[`DTC_T0_GATE_BIT] |
	                             ext_gate_pin_0);
	wire       run1     = (split0 | tr1) &
	                      (~timer_mode_reg[`DTC_T1_GATE_BIT] |
	                       ext_gate_pin_1);
	wire       inc0     = run0 & ev0;
	wire       inc1     = run1 & ev1 &
	                      (mode1 != `DTC_MODE_SPLIT);
	wire       inc_th0  = split0 & tr1 & tick0;

	// ==========================================================
	// timer 0 next counts
	always @* begin
		s0       = dtc_step(mode0, tl0_reg, th0_reg);
		ovf0     = inc0 & s0[16];
		ovf_th0  = inc_th0 & (th0_reg == 8'hFF);
		tl0_next = inc0 ? s0[7:0] : tl0_reg;
		th0_next = th0_reg;
		if (split0) begin
			if (inc_th0) begin
				th0_next = th0_reg + 8'h01;
			end
		end else if (inc0) begin
			th0_next = s0[15:8];
		end
		if (wr_tl0) begin
			tl0_next = pwdata[7:0];
		end
		if (wr_th0) begin
			th0_next = pwdata[7:0];
		end
	end

	// ==========================================================
	// timer 1 next counts
	always @* begin
		s1       = dtc_step(mode1, tl1_reg, th1_reg);
		ovf1     = inc1 & s1[16];
		tl1_next = inc1 ? s1[7:0] : tl1_reg;
		th1_next = inc1 ? s1[15:8] : th1_reg;
		if (wr_tl1) begin
			tl1_next = pwdata[7:0];
		end
		if (wr_th1) begin
			th1_next = pwdata[7:0];
		end
	end

	// ==========================================================
	// control next: overflow beats clearing write
	always @* begin
		timer_control_next = wr_timer_control ? pwdata[7:0] : timer_control_reg;
		if (ovf0) begin
			timer_control_next[`DTC_TF0_BIT] = 1'b1;
		end
		if (ovf_th0 | (ovf1 & ~split0)) begin
			timer_control_next[`DTC_TF1_BIT] = 1'b1;
		end
	end

	// ==========================================================
	// read mux
	always @* begin
		rd_hit  = aligned;
		rd_byte = 8'h00;
		case (widx)
		`DTC_IDX_TIMER_CONTROL: rd_byte = timer_control_reg;
		`DTC_IDX_TIMER_MODE: rd_byte = timer_mode_reg;
		`DTC_IDX_TL0:  rd_byte = tl0_reg;
		`DTC_IDX_TL1:  rd_byte = tl1_reg;
		`DTC_IDX_TH0:  rd_byte = th0_reg;
		`DTC_IDX_TH1:  rd_byte = th1_reg;
		`DTC_IDX_AUX:  rd_byte = aux_reg;
		`DTC_IDX_CLKO: rd_byte = clko_reg;
		default:       rd_hit  = 1'b0;
		endcase
	end

	// ==========================================================
	// apb ready: one wait cycle
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= access & ~pready;
		end
	end

	// ==========================================================
	// apb error: unmapped or misaligned
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pslverr <= 1'b0;
		end else begin
			if (access & ~pready) begin
				pslverr <= ~rd_hit;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// ==========================================================
	// apb read data
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h00000000;
		end else begin
			if (access & ~pready) begin
				prdata <= (rd_hit & ~pwrite) ?
				          {24'h000000, rd_byte} : 32'h00000000;
			end
		end
	end

	// ==========================================================
	// free-running divide-by-twelve
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= tick12 ? 4'h0 : div_reg + 4'h1;
		end
	end

	// ==========================================================
	// count pin sample pairs
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cin0_reg     <= 1'b0;
			cin0_old_reg <= 1'b0;
			cin1_reg     <= 1'b0;
			cin1_old_reg <= 1'b0;
		end else begin
			cin0_reg     <= count_input_0;
			cin0_old_reg <= cin0_reg;
			cin1_reg     <= count_input_1;
			cin1_old_reg <= cin1_reg;
		end
	end

	// ==========================================================
	// timer 0 count bytes
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tl0_reg <= `DTC_RST_BYTE;
			th0_reg <= `DTC_RST_BYTE;
		end else begin
			tl0_reg <= tl0_next;
			th0_reg <= th0_next;
		end
	end

	// ==========================================================
	// timer 1 count bytes
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tl1_reg <= `DTC_RST_BYTE;
			th1_reg <= `DTC_RST_BYTE;
		end else begin
			tl1_reg <= tl1_next;
			th1_reg <= th1_next;
		end
	end

	// ==========================================================
	// control register
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_control_reg <= `DTC_RST_BYTE;
		end else begin
			timer_control_reg <= timer_control_next;
		end
	end

	// ==========================================================
	// mode register
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_mode_reg <= `DTC_RST_BYTE;
		end else begin
			if (wr_timer_mode) begin
				timer_mode_reg <= pwdata[7:0];
			end
		end
	end

	// ==========================================================
	// prescale select register
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aux_reg <= `DTC_RST_BYTE;
		end else begin
			if (wr_aux) begin
				aux_reg <= pwdata[7:0];
			end
		end
	end

	// ==========================================================
	// clock-out enable register
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clko_reg <= `DTC_RST_BYTE;
		end else begin
			if (wr_clko) begin
				clko_reg <= pwdata[7:0];
			end
		end
	end

	// ==========================================================
	// clock output pins
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer0_output_pin <= 1'b0;
			timer1_output_pin <= 1'b0;
		end else begin
			if (ovf0 & clko_reg[`DTC_T0_CLKO_BIT]) begin
				timer0_output_pin <= ~timer0_output_pin;
			end
			if (ovf1 & clko_reg[`DTC_T1_CLKO_BIT]) begin
				timer1_output_pin <= ~timer1_output_pin;
			end
		end
	end

	// ==========================================================
	// overflow flag outputs
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer0_overflow_flag <= 1'b0;
			timer1_overflow_flag <= 1'b0;
		end else begin
			timer0_overflow_flag <= timer_control_next[`DTC_TF0_BIT];
			timer1_overflow_flag <= timer_control_next[`DTC_TF1_BIT];
		end
	end

endmodule

// *** sim/dtc_checker.sv ***
// ==========================================================
// port checker
module dtc_checker (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        timer0_output_pin,
	input wire logic        timer0_overflow_flag,
	input wire logic        timer1_overflow_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// ======================================================
	// bus answers
	a_ready_wait: assert property ($rose(penable) && psel
		|-> !pready ##1 pready) else $error("ready timing");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_read_byte: assert property (pready && !pwrite
		|-> prdata[31:8] == 24'h0) else $error("upper read bits");
	a_err_no_load: assert property (pslverr && pwrite
		|=> !$fell(timer0_overflow_flag)) else $error("refused write");
	// ======================================================
	// flags and pins
	a_flag0_clear: assert property ($fell(timer0_overflow_flag)
		|-> $past(pready && pwrite)) else $error("flag 0 fell");
	a_flag1_clear: assert property ($fell(timer1_overflow_flag)
		|-> $past(pready && pwrite)) else $error("flag 1 fell");
	a_pin0_flag: assert property ($changed(timer0_output_pin)
		|-> timer0_overflow_flag) else $error("pin 0 toggle");
	cover property ($rose(timer0_overflow_flag));
	cover property ($rose(timer1_overflow_flag));
	cover property (pslverr);
endmodule

bind dtc_top dtc_checker i_chk (.clk, .arst_n, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .timer0_output_pin,
	.timer0_overflow_flag, .timer1_overflow_flag);

// *** sim/dtc_pins.sv ***
// ==========================================================
// count and gate pin source
module dtc_pins (
	input  wire logic clk,
	output logic      count_input_0,
	output logic      count_input_1,
	output logic      ext_gate_pin_0,
	output logic      ext_gate_pin_1
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		count_input_0 = 1'h1;
		count_input_1 = 1'h1;
		ext_gate_pin_0 = 1'h1;
		ext_gate_pin_1 = 1'h1;
	end
	task automatic drive(input int t, input logic v);
		@(posedge clk);
		if (t == 0)
			count_input_0 <= v;
		else
			count_input_1 <= v;
		repeat (2) @(posedge clk);
	endtask
	task automatic pulse(input int t, input int n);
		repeat (n) begin
			drive(t, 1'h0);
			drive(t, 1'h1);
		end
	endtask
	task automatic gate(input int t, input logic v);
		@(posedge clk);
		if (t == 0)
			ext_gate_pin_0 <= v;
		else
			ext_gate_pin_1 <= v;
	endtask
endmodule

// *** sim/dual_timer_counter_tb_top.sv ***
`include "dtc_regs.vh"
module dual_timer_counter_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, arst_n, psel, penable, pwrite, e;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [7:0]  q;
	wire  [31:0] prdata;
	wire         pready, pslverr, count_input_0, count_input_1;
	wire         ext_gate_pin_0, ext_gate_pin_1;
	wire         timer0_output_pin, timer1_output_pin;
	wire         timer0_overflow_flag, timer1_overflow_flag;
	int          err_total, check_count, cyc, i;
	dtc_top i_dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .count_input_0, .count_input_1,
		.ext_gate_pin_0, .ext_gate_pin_1, .timer0_output_pin,
		.timer1_output_pin, .timer0_overflow_flag, .timer1_overflow_flag);
	dtc_pins i_pins (.clk, .count_input_0, .count_input_1, .ext_gate_pin_0,
		.ext_gate_pin_1);
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop;
		end
	end
	// ======================================================
	// tasks
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input [7:0] g, input [7:0] x);
		check_count++;
		if (g !== x) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic apb(input w, input [7:0] a, input [7:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, a, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input [7:0] a, input [7:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rd(input [7:0] a, input [7:0] x);
		apb(1'h0, a, 8'h00);
		chk(q, x);
	endtask
	task automatic rng(input [7:0] a, input [7:0] lo, input [7:0] hi);
		apb(1'h0, a, 8'h00);
		chk(q < lo || q > hi, 8'h00);
	endtask
	// ======================================================
	// sequence
	initial begin
		arst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		repeat (8) @(posedge clk);
		arst_n <= 1'h1;
		for (i = 0; i < 8; i++)
			rd(8'h88 + i, `DTC_RST_BYTE);
		apb(1'h1, 8'h90, 8'h00);
		chk({7'h0, e}, 8'h01);
		wr(`DTC_IDX_TIMER_MODE, 8'h11);
		for (i = 0; i < 2; i++) begin
			wr(`DTC_IDX_AUX, i ? 8'h00 : 8'hC0);
			wr(`DTC_IDX_TL0, 8'h00);
			wr(`DTC_IDX_TL1, 8'h00);
			wr(`DTC_IDX_TIMER_CONTROL, 8'h50);
			repeat (240) @(posedge clk);
			wr(`DTC_IDX_TIMER_CONTROL, 8'h00);
			rng(`DTC_IDX_TL0, i ? 8'h13 : 8'hF0, i ? 8'h15 : 8'hF7);
			rng(`DTC_IDX_TL1, i ? 8'h13 : 8'hF0, i ? 8'h15 : 8'hF7);
		end
		wr(`DTC_IDX_CLKO, 8'h03);
		wr(`DTC_IDX_TIMER_MODE, 8'h05);
		wr(`DTC_IDX_TL0, 8'hFE);
		wr(`DTC_IDX_TH0, 8'hFF);
		wr(`DTC_IDX_TIMER_CONTROL, 8'h10);
		i_pins.pulse(0, 2);
		rd(`DTC_IDX_TL0, 8'h00);
		rd(`DTC_IDX_TH0, 8'h00);
		rd(`DTC_IDX_TIMER_CONTROL, 8'h30);
		chk({7'h0, timer0_output_pin}, 8'h01);
		wr(`DTC_IDX_TIMER_MODE, 8'h0D);
		wr(`DTC_IDX_TIMER_CONTROL, 8'h10);
		i_pins.gate(0, 1'h0);
		i_pins.pulse(0, 1);
		rd(`DTC_IDX_TL0, 8'h00);
		i_pins.gate(0, 1'h1);
		i_pins.pulse(0, 1);
		rd(`DTC_IDX_TL0, 8'h01);
		wr(`DTC_IDX_TIMER_MODE, 8'h60);
		wr(`DTC_IDX_TH1, 8'hF0);
		wr(`DTC_IDX_TL1, 8'hFF);
		wr(`DTC_IDX_TIMER_CONTROL, 8'h40);
		i_pins.pulse(1, 1);
		rd(`DTC_IDX_TL1, 8'hF0);
		rd(`DTC_IDX_TH1, 8'hF0);
		rd(`DTC_IDX_TIMER_CONTROL, 8'hC0);
		chk({7'h0, timer1_output_pin}, 8'h01);
		wr(`DTC_IDX_TIMER_MODE, 8'h40);
		wr(`DTC_IDX_TH1, 8'h00);
		wr(`DTC_IDX_TL1, 8'hFF);
		i_pins.pulse(1, 1);
		rd(`DTC_IDX_TL1, 8'hE0);
		rd(`DTC_IDX_TH1, 8'h01);
		wr(`DTC_IDX_TIMER_CONTROL, 8'h00);
		wr(`DTC_IDX_TL1, 8'h55);
		wr(`DTC_IDX_TIMER_MODE, 8'h33);
		wr(`DTC_IDX_AUX, 8'hC0);
		wr(`DTC_IDX_TL0, 8'hFF);
		wr(`DTC_IDX_TH0, 8'hFF);
		wr(`DTC_IDX_TIMER_CONTROL, 8'h50);
		rd(`DTC_IDX_TIMER_CONTROL, 8'hF0);
		rd(`DTC_IDX_TL1, 8'h55);
		report_and_stop;
	end
endmodule
